// *** rfc_params.svh ***
// constants for the reference control register block
`ifndef RFC_PARAMS_SVH
`define RFC_PARAMS_SVH

// ********************************************************
// register map (byte address, printed offset is not a multiple of four: index x 4)
// ********************************************************
`define RFC_REF_CTRL_INDEX      8'hd1
`define RFC_REF_CTRL_ADDR       12'h344
`define RFC_ADDR_W              12
`define RFC_REG_RESET           8'h00
`define RFC_REG_MSB             7
`define RFC_WRITE_LANE          0

// ********************************************************
// field positions
// ********************************************************
`define RFC_BIT_MERGE           7
`define RFC_BIT_FLAG            6
`define RFC_BIT_ZTC             5
`define RFC_BIT_LEVEL           4
`define RFC_BIT_SOURCE          3
`define RFC_BIT_TEMP            2
`define RFC_BIT_BIAS            1
`define RFC_BIT_BUF             0

`endif

// *** rfc_pkg.sv ***
// types for the reference control register block
package rfc_pkg;
    typedef logic [7:0] rfc_reg_t;
endpackage : rfc_pkg

// *** rfc_reference_control.sv ***
// reference control register with apb slave and analog control outputs
// What this block does
// RULE1 - one 8-bit read/write register at index 0xd1, all zeros after reset.
// RULE2 - bit 7 routes the second dac to its own pin (0) or merges it onto the first dac pin (1).
// RULE3 - bit 6 is a free software flag with no hardware effect.
// RULE4 - bit 5 forces the zero-tempco bias on, else it runs only when needed.
// RULE5 - bit 4 selects the reference level, 0 for 1.5 V and 1 for 2.2 V.
// RULE6 - bit 3 selects the reference pin (0) or the supply (1) as reference.
// RULE7 - bit 2 enables the temperature sensor, whose output floats while off.
// RULE8 - bit 1 enables the bias generator, also forced on by dependent peripherals.
// RULE9 - bit 0 enables the reference buffer that drives the reference pin.
// RULE10 - software keeps the buffer enable at 0 when the internal reference is unused.
// RULE11 - software sets the reference pin analog and skipped in the crossbar.
// RULE12 - with both dacs on and merge set, both outputs combine on the first dac pin.
// RULE13 - the effective bias enable is the OR of the stored bit and all dependent enables.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "rfc_params.svh"

module rfc_reference_control (
    input  wire logic                     clk_sys,
    input  wire logic                     reset_n,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`RFC_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     adcEnable,
    input  wire logic                     oscEnable,
    input  wire logic                     firstDacEnable,
    input  wire logic                     secondDacEnable,
    input  wire logic                     ztcNeeded,
    output logic                          secondDacToFirstPin,
    output logic                          dacOutputsMerged,
    output logic                          zeroTempcoBiasOn,
    output logic                          referenceLevelHigh,
    output logic                          referenceFromSupply,
    output logic                          tempSensorEnable,
    output logic                          analogBiasOn,
    output logic                          referenceBufferEnable,
    output logic                          spareSoftwareFlag
);

    // ********************************************************
    // apb slave
    // ********************************************************
    rfc_pkg::rfc_reg_t referenceControl_ff;
    logic              hit;
    logic              access;

    // one decode shared by the slave and all checks but p_err_hit, which repeats the compare inline
    function automatic logic addr_is_reg(input logic [`RFC_ADDR_W-1:0] addr);
        return addr == `RFC_ADDR_W'(`RFC_REF_CTRL_ADDR);
    endfunction : addr_is_reg

    assign hit     = addr_is_reg(paddr);
    assign access  = psel && penable;
    // zero wait states keep the cpu side simple
    assign pready  = 1'b1;
    assign pslverr = access && !hit;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            referenceControl_ff <= `RFC_REG_RESET;                        // [RULE1]
        end else if (access && pwrite && hit && pstrb[`RFC_WRITE_LANE]) begin
            referenceControl_ff <= pwdata[`RFC_REG_MSB:0];                // [RULE1] [RULE3]
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= hit ? {24'h00_0000, referenceControl_ff} : 32'h0000_0000; // [RULE1]
        end
    end

    // ********************************************************
    // analog controls
    // ********************************************************
    assign secondDacToFirstPin   = referenceControl_ff[`RFC_BIT_MERGE];       // [RULE2]
    assign dacOutputsMerged      = referenceControl_ff[`RFC_BIT_MERGE]
                                   && firstDacEnable && secondDacEnable;     // [RULE12]
    assign zeroTempcoBiasOn      = referenceControl_ff[`RFC_BIT_ZTC] || ztcNeeded; // [RULE4]
    assign referenceLevelHigh    = referenceControl_ff[`RFC_BIT_LEVEL];       // [RULE5]
    assign referenceFromSupply   = referenceControl_ff[`RFC_BIT_SOURCE];      // [RULE6]
    // sensor output high impedance is handled in the analog cell while this is low
    assign tempSensorEnable      = referenceControl_ff[`RFC_BIT_TEMP];        // [RULE7]
    assign analogBiasOn          = referenceControl_ff[`RFC_BIT_BIAS] || adcEnable
                                   || tempSensorEnable || oscEnable
                                   || firstDacEnable || secondDacEnable;     // [RULE8] [RULE13]
    assign referenceBufferEnable = referenceControl_ff[`RFC_BIT_BUF];         // [RULE9]
    // flag is exported only for observation, nothing in hardware uses it
    assign spareSoftwareFlag     = referenceControl_ff[`RFC_BIT_FLAG];        // [RULE3]

    // ********************************************************
    // checks
    // ********************************************************
    property p_reset_zero;
        @(posedge clk_sys) $rose(reset_n) |-> referenceControl_ff == `RFC_REG_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset"); // [RULE1]

    sequence s_write;
        psel && penable && pwrite && hit && pstrb[0];
    endsequence
    property p_write_store;
        @(posedge clk_sys) disable iff (!reset_n)
            s_write |=> referenceControl_ff == $past(pwdata[7:0]);
    endproperty
    a_write_store: assert property (p_write_store) else $error("write not stored"); // [RULE1]

    property p_merge;
        @(posedge clk_sys) disable iff (!reset_n)
            secondDacToFirstPin == referenceControl_ff[`RFC_BIT_MERGE]
            && (dacOutputsMerged == (secondDacToFirstPin && firstDacEnable && secondDacEnable));
    endproperty
    a_merge: assert property (p_merge) else $error("merge routing wrong"); // [RULE2] [RULE12]

    property p_ztc;
        @(posedge clk_sys) disable iff (!reset_n)
            referenceControl_ff[`RFC_BIT_ZTC] |-> zeroTempcoBiasOn;
    endproperty
    a_ztc: assert property (p_ztc) else $error("zero tempco bias not forced"); // [RULE4]

    property p_level_source;
        @(posedge clk_sys) disable iff (!reset_n)
            s_write |=> referenceLevelHigh == $past(pwdata[`RFC_BIT_LEVEL])
                     && referenceFromSupply == $past(pwdata[`RFC_BIT_SOURCE]);
    endproperty
    a_level_source: assert property (p_level_source) // [RULE5] [RULE6]
        else $error("level or source wrong");

    property p_temp;
        @(posedge clk_sys) disable iff (!reset_n)
            s_write |=> tempSensorEnable == $past(pwdata[`RFC_BIT_TEMP]);
    endproperty
    a_temp: assert property (p_temp) else $error("sensor enable wrong"); // [RULE7]

    property p_bias;
        @(posedge clk_sys) disable iff (!reset_n)
            (adcEnable || oscEnable || firstDacEnable || secondDacEnable
             || referenceControl_ff[`RFC_BIT_BIAS] || tempSensorEnable) == analogBiasOn;
    endproperty
    a_bias: assert property (p_bias) else $error("bias enable wrong"); // [RULE8] [RULE13]

    property p_buf;
        @(posedge clk_sys) disable iff (!reset_n)
            s_write |=> referenceBufferEnable == $past(pwdata[`RFC_BIT_BUF]);
    endproperty
    a_buf: assert property (p_buf) else $error("buffer enable wrong"); // [RULE9]

    property p_flag;
        @(posedge clk_sys) disable iff (!reset_n)
            s_write |=> spareSoftwareFlag == $past(pwdata[`RFC_BIT_FLAG]);
    endproperty
    a_flag: assert property (p_flag) else $error("flag not stored"); // [RULE3]

    // ********************************************************
    // bus checks
    // ********************************************************
    sequence s_access;
        psel && penable;
    endsequence

    sequence s_write_miss;
        psel && penable && pwrite && !addr_is_reg(paddr);
    endsequence

    sequence s_write_no_lane;
        psel && penable && pwrite && !pstrb[`RFC_WRITE_LANE];
    endsequence

    sequence s_read_setup_hit;
        psel && !penable && !pwrite && addr_is_reg(paddr);
    endsequence

    sequence s_read_setup_miss;
        psel && !penable && !pwrite && !addr_is_reg(paddr);
    endsequence

    // zero wait states: a master never has to stretch an access phase
    property p_ready;
        @(posedge clk_sys) disable iff (!reset_n)
            s_access |-> pready;
    endproperty
    a_ready: assert property (p_ready) // [RULE1]
        else $error("access phase not ready");

    property p_err_miss;
        @(posedge clk_sys) disable iff (!reset_n)
            s_write_miss |-> pslverr;
    endproperty
    a_err_miss: assert property (p_err_miss) // [RULE1]
        else $error("unmapped write without error");

    property p_err_hit;
        @(posedge clk_sys) disable iff (!reset_n)
            psel && penable && (paddr == `RFC_ADDR_W'(`RFC_REF_CTRL_ADDR)) |-> !pslverr;
    endproperty
    a_err_hit: assert property (p_err_hit) // [RULE1]
        else $error("mapped access flagged as error");

    property p_miss_ignored;
        @(posedge clk_sys) disable iff (!reset_n)
            s_write_miss |=> $stable(referenceControl_ff);
    endproperty
    a_miss_ignored: assert property (p_miss_ignored) // [RULE1]
        else $error("unmapped write changed the register");

    property p_lane_ignored;
        @(posedge clk_sys) disable iff (!reset_n)
            s_write_no_lane |=> $stable(referenceControl_ff);
    endproperty
    a_lane_ignored: assert property (p_lane_ignored) // [RULE1]
        else $error("write without strobe changed the register");

    property p_hold;
        @(posedge clk_sys) disable iff (!reset_n)
            !(psel && penable && pwrite) |=> $stable(referenceControl_ff);
    endproperty
    a_hold: assert property (p_hold) // [RULE1]
        else $error("register changed without a write");

    // read data is captured in the setup phase and must still stand at the access edge
    property p_read_hit;
        @(posedge clk_sys) disable iff (!reset_n)
            s_read_setup_hit |=> prdata == {24'h00_0000, $past(referenceControl_ff)};
    endproperty
    a_read_hit: assert property (p_read_hit) // [RULE1]
        else $error("read data does not match the register");

    property p_read_miss;
        @(posedge clk_sys) disable iff (!reset_n)
            s_read_setup_miss |=> prdata == 32'h0000_0000;
    endproperty
    a_read_miss: assert property (p_read_miss) // [RULE1]
        else $error("unmapped read not zero");

    property p_read_hold;
        @(posedge clk_sys) disable iff (!reset_n)
            !(psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    a_read_hold: assert property (p_read_hold) // [RULE1]
        else $error("read data changed outside a read setup");

    property p_reset_read;
        @(posedge clk_sys) $rose(reset_n) |-> prdata == 32'h0000_0000;
    endproperty
    a_reset_read: assert property (p_reset_read) // [RULE1]
        else $error("read data not zero after reset");

    // ********************************************************
    // control checks
    // ********************************************************
    sequence s_bias_demand;
        adcEnable || oscEnable || firstDacEnable || secondDacEnable || tempSensorEnable;
    endsequence

    property p_merge_write;
        @(posedge clk_sys) disable iff (!reset_n)
            s_write |=> secondDacToFirstPin == $past(pwdata[`RFC_BIT_MERGE]);
    endproperty
    a_merge_write: assert property (p_merge_write) // [RULE2]
        else $error("merge select not taken from write");

    // one dac alone never counts as merged, even with the select set
    property p_merged_needs_both;
        @(posedge clk_sys) disable iff (!reset_n)
            dacOutputsMerged |-> firstDacEnable && secondDacEnable && secondDacToFirstPin;
    endproperty
    a_merged_needs_both: assert property (p_merged_needs_both) // [RULE12]
        else $error("merge shown without both dacs");

    property p_merged_when_all;
        @(posedge clk_sys) disable iff (!reset_n)
            secondDacToFirstPin && firstDacEnable && secondDacEnable |-> dacOutputsMerged;
    endproperty
    a_merged_when_all: assert property (p_merged_when_all) // [RULE12]
        else $error("merge missing with both dacs on");

    property p_ztc_auto;
        @(posedge clk_sys) disable iff (!reset_n)
            !referenceControl_ff[`RFC_BIT_ZTC] |-> zeroTempcoBiasOn == ztcNeeded;
    endproperty
    a_ztc_auto: assert property (p_ztc_auto) // [RULE4]
        else $error("zero tempco bias not following demand");

    property p_bias_forced;
        @(posedge clk_sys) disable iff (!reset_n)
            s_bias_demand |-> analogBiasOn;
    endproperty
    a_bias_forced: assert property (p_bias_forced) // [RULE8]
        else $error("bias not forced by a dependent");

    // with no dependent on, only the stored bit may keep the generator running
    property p_bias_alone;
        @(posedge clk_sys) disable iff (!reset_n)
            !(adcEnable || oscEnable || firstDacEnable || secondDacEnable || tempSensorEnable)
            |-> analogBiasOn == referenceControl_ff[`RFC_BIT_BIAS];
    endproperty
    a_bias_alone: assert property (p_bias_alone) // [RULE13]
        else $error("bias on without a reason");

    property p_bias_write;
        @(posedge clk_sys) disable iff (!reset_n)
            s_write |=> !$past(pwdata[`RFC_BIT_BIAS]) || analogBiasOn;
    endproperty
    a_bias_write: assert property (p_bias_write) // [RULE8]
        else $error("written bias enable not applied");

endmodule : rfc_reference_control

// *** test_reference_control_register.sv ***
// self-checking bench for the reference control register block
`timescale 1ns/1ps
`include "rfc_params.svh"

module test_reference_control_register;
    // ****
    // signals
    // ****
    logic                   clk_sys = 1'b0;
    logic                   reset_n = 1'b0;
    logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [`RFC_ADDR_W-1:0] paddr = '0;
    logic [31:0]            pwdata = '0, prdata, rdata;
    logic [3:0]             pstrb = 4'h1;
    logic                   pready, pslverr, rerr;
    logic [4:0]             periph = 5'h00;
    wire  [8:0]             outs;
    int                     error_cnt = 0, check_count = 0;
    // rows: register value, {adc, osc, first dac, second dac, ztc need}, outputs expected
    // rows that enable the buffer keep the pin as the reference source
    logic [21:0] rows [17] = '{{8'h80,5'h00,9'h100}, {8'h80,5'h06,9'h184}, {8'h40,5'h00,9'h001},
        {8'h20,5'h00,9'h040}, {8'h00,5'h01,9'h040}, {8'h10,5'h00,9'h020}, {8'h08,5'h00,9'h010},
        {8'h04,5'h00,9'h00c}, {8'h02,5'h00,9'h004}, {8'h01,5'h00,9'h002}, {8'h00,5'h10,9'h004},
        {8'h00,5'h08,9'h004}, {8'h00,5'h02,9'h004}, {8'h00,5'h04,9'h004}, {8'h80,5'h04,9'h104},
        {8'hf7,5'h00,9'h16f}, {8'h77,5'h06,9'h06f}};
    always #12.5 clk_sys = ~clk_sys;
    rfc_reference_control dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .adcEnable(periph[4]),
        .oscEnable(periph[3]), .firstDacEnable(periph[2]), .secondDacEnable(periph[1]),
        .ztcNeeded(periph[0]), .secondDacToFirstPin(outs[8]), .dacOutputsMerged(outs[7]),
        .zeroTempcoBiasOn(outs[6]), .referenceLevelHigh(outs[5]), .referenceFromSupply(outs[4]),
        .tempSensorEnable(outs[3]), .analogBiasOn(outs[2]), .referenceBufferEnable(outs[1]),
        .spareSoftwareFlag(outs[0]));
    // ****
    // tasks
    // ****
    task automatic final_report();
        if (error_cnt == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // request held until pready is seen high; the answer is taken at that edge only
    task automatic apb(input logic wr, input logic [`RFC_ADDR_W-1:0] a, input logic [7:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            error_cnt++;
            final_report();
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // ****
    // sequence
    // ****
    initial begin
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        apb(1'b0, `RFC_REF_CTRL_ADDR, 8'h00, 4'h1);
        chk("reset value", rdata, 32'h0);
        chk("reset outputs", 32'(outs), 32'h0);
        for (int i = 0; i < 17; i++) begin
            periph <= rows[i][13:9];
            apb(1'b1, `RFC_REF_CTRL_ADDR, rows[i][21:14], 4'h1);
            apb(1'b0, `RFC_REF_CTRL_ADDR, 8'h00, 4'h1);
            chk("readback", rdata, {24'h0, rows[i][21:14]});
            chk("dac routing", 32'(outs[8:7]), 32'(rows[i][8:7]));
            chk("reference", 32'(outs[6:4]), 32'(rows[i][6:4]));
            chk("sensor and bias", 32'(outs[3:2]), 32'(rows[i][3:2]));
            chk("buffer and flag", 32'(outs[1:0]), 32'(rows[i][1:0]));
        end
        // unmapped and strobe-less writes must leave the stored value alone
        apb(1'b1, 12'h340, 8'h00, 4'h1);
        chk("unmapped write error", 32'(rerr), 32'h1);
        apb(1'b0, 12'h340, 8'h00, 4'h1);
        chk("unmapped read", rdata, 32'h0);
        apb(1'b1, `RFC_REF_CTRL_ADDR, 8'h00, 4'h0);
        apb(1'b0, `RFC_REF_CTRL_ADDR, 8'h00, 4'h1);
        chk("register kept", rdata, 32'h77);
        chk("mapped error", 32'(rerr), 32'h0);
        // pin mode and crossbar skip of the reference pin belong to the port block
        periph <= 5'h06;
        reset_n <= 1'b0;
        @(posedge clk_sys);
        chk("reset mid run", 32'(outs), 32'h004);
        reset_n <= 1'b1;
        periph <= 5'h00;
        apb(1'b0, `RFC_REF_CTRL_ADDR, 8'h00, 4'h1);
        chk("cleared value", rdata, 32'h0);
        final_report();
    end
endmodule : test_reference_control_register
